// >>> hw/modbus_coil_register_map.sv
// coil and holding-register map of the drive's serial slave
`timescale 1ns/100ps
`include "modbus_map_consts.svh"
module modbus_coil_register_map #(
	parameter int PARAM_COUNT = `DEFAULT_PARAMS,
	parameter int PNU_W       = $clog2(PARAM_COUNT)
) (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  ce,
	// one decoded item from the frame layer
	input  wire logic                  req_valid,
	input  wire logic                  req_coil,
	input  wire logic                  req_write,
	input  wire logic [15:0]           req_addr,
	input  wire modbus_map_pkg::word_t req_wdata,
	output logic                       resp_valid,
	output modbus_map_pkg::word_t      resp_data,
	output logic                       resp_exception,
	// converter state inputs
	input  wire logic                  control_ready,
	input  wire logic                  converter_ready,
	input  wire logic                  safety_closed,
	input  wire logic                  alarm,
	input  wire logic                  warning,
	input  wire logic                  at_reference,
	input  wire logic                  auto_mode,
	input  wire logic                  in_freq_range,
	input  wire logic                  running,
	input  wire logic                  voltage_warning,
	input  wire logic                  current_limit,
	input  wire logic                  thermal_warning,
	input  wire logic                  closed_loop,
	input  wire modbus_map_pkg::word_t output_frequency,
	input  wire modbus_map_pkg::word_t feedback_value,
	input  wire modbus_map_pkg::word_t actual_value,
	input  wire logic                  error_strobe,
	input  wire modbus_map_pkg::word_t error_code,
	// command outputs
	output modbus_map_pkg::word_t      drive_command_word,
	output modbus_map_pkg::word_t      bus_speed_setpoint,
	output logic [1:0]                 preset_ref_sel,
	output logic [1:0]                 setup_sel,
	output logic                       dc_brake_n,
	output logic                       coast_stop_n,
	output logic                       quick_stop_n,
	output logic                       freeze_n,
	output logic                       start,
	output logic                       fault_reset,
	output logic                       jog,
	output logic                       ramp2_sel,
	output logic                       data_valid,
	output logic                       relay1_on,
	output logic                       relay2_on,
	output logic                       reverse,
	output logic                       store_to_eeprom,
	output modbus_map_pkg::word_t      last_error_code,
	output modbus_map_pkg::word_t      parameter_array_index,
	// parameter write notice to the converter
	output logic                       param_wr_strobe,
	output logic [PNU_W-1:0]           param_wr_number,
	output modbus_map_pkg::word_t      param_wr_value,
	output modbus_map_pkg::word_t      param_wr_index,
	output logic                       param_wr_eeprom
);
	import modbus_map_pkg::*;

	// all registered state of the map
	typedef struct packed {
		logic             pend;        // an item waits for its answer
		sel_t             pend_sel;    // where it landed
		logic [3:0]       pend_bit;    // coil position within its word
		logic             pend_exc;    // refused at decode
		logic             pend_write;  // it was a write
		logic             resp_valid;
		word_t            resp_data;
		logic             resp_exc;
		word_t            cmd;
		word_t            setpoint;
		logic             store_sel;
		word_t            err_code;
		word_t            arr_index;
		word_t            status;
		word_t            fb;
		word_t            actual;
		logic             pw_strobe;
		logic [PNU_W-1:0] pw_number;
		word_t            pw_value;
		word_t            pw_index;
		logic             pw_eeprom;
	} regs_t;

	regs_t            st;         // registered state
	regs_t            next_st;    // next state
	sel_t             sel;        // decode of the incoming item
	logic [3:0]       coil_bit;   // bit of the incoming coil in its word
	logic [16:0]      reg_num;    // user register number
	logic [16:0]      pnu_full;   // register number over ten
	logic [PNU_W-1:0] pnu;        // parameter number into the store
	logic             read_only;  // selection a master may not write
	logic             take;       // item accepted this cycle
	word_t            mem_rdata;  // parameter read word, registered

	// address decode; every selection is one bit or one word
	always_comb begin
		reg_num  = {1'b0, req_addr} + `REG_NUM_ONE;
		pnu_full = reg_num / `REG_PARAM_STRIDE;
		pnu      = pnu_full[PNU_W-1:0];
		coil_bit = req_addr[3:0];
		sel      = SEL_BAD;
		if (req_coil) begin
			if (req_addr < `COIL_REF_BASE) begin
				sel = SEL_COIL_CMD;
			end else if (req_addr < `COIL_STAT_BASE) begin
				sel = SEL_COIL_REF;
			end else if (req_addr < `COIL_FB_BASE) begin
				sel = SEL_COIL_STAT;
			end else if (req_addr < `COIL_STORE_SEL) begin
				sel = SEL_COIL_FB;
			end else if (req_addr == `COIL_STORE_SEL) begin
				sel = SEL_COIL_STORE;
			end
		end else begin
			if (reg_num == `REG_ERR_CODE) begin
				sel = SEL_ERR;
			end else if (reg_num == `REG_ARRAY_INDEX) begin
				sel = SEL_INDEX;
			end else if (reg_num == `REG_CMD_WORD) begin
				sel = SEL_CMD_WORD;
			end else if (reg_num == `REG_SETPOINT) begin
				sel = SEL_SETPOINT;
			end else if (reg_num == `REG_STATE_WORD) begin
				sel = SEL_STATE_WORD;
			end else if (reg_num == `REG_ACTUAL) begin
				sel = SEL_ACTUAL;
			end else if (reg_num >= `REG_PARAM_FIRST && reg_num <= `REG_PARAM_LAST
				&& reg_num % `REG_PARAM_STRIDE == 17'h0
				&& pnu_full < 17'(PARAM_COUNT)) begin
				sel = SEL_PARAM;
			end
		end
		// the state and feedback groups carry data toward the master only
		read_only = (sel == SEL_COIL_STAT) || (sel == SEL_COIL_FB) || (sel == SEL_ERR)
			|| (sel == SEL_STATE_WORD) || (sel == SEL_ACTUAL);
		take      = req_valid;
	end

	// next state: writes land at the taking edge, answers one edge later
	always_comb begin
		next_st = st;
		// state word, with unused positions forced to zero
		next_st.status                     = `RST_WORD;
		next_st.status[`STW_CTRL_READY]    = control_ready;
		next_st.status[`STW_CONV_READY]    = converter_ready;
		next_st.status[`STW_SAFETY_CLOSED] = safety_closed;
		next_st.status[`STW_ALARM]         = alarm;
		next_st.status[`STW_WARNING]       = warning;
		next_st.status[`STW_AT_REF]        = at_reference;
		next_st.status[`STW_AUTO]          = auto_mode;
		next_st.status[`STW_IN_RANGE]      = in_freq_range;
		next_st.status[`STW_RUNNING]       = running;
		next_st.status[`STW_VOLT_WARN]     = voltage_warning;
		next_st.status[`STW_CURR_LIMIT]    = current_limit;
		next_st.status[`STW_THERMAL_WARN]  = thermal_warning;
		next_st.fb        = closed_loop ? feedback_value : output_frequency;
		next_st.actual    = actual_value;
		next_st.pw_strobe = 1'b0;
		if (error_strobe) begin
			next_st.err_code = error_code;
		end
		// answer stage for the item taken one edge before
		next_st.resp_valid = st.pend;
		next_st.resp_exc   = st.pend && st.pend_exc;
		next_st.resp_data  = `RST_WORD;
		if (st.pend && !st.pend_exc && !st.pend_write) begin
			unique case (st.pend_sel)
				SEL_COIL_CMD:   next_st.resp_data[0] = st.cmd[st.pend_bit];
				SEL_COIL_REF:   next_st.resp_data[0] = st.setpoint[st.pend_bit];
				SEL_COIL_STAT:  next_st.resp_data[0] = st.status[st.pend_bit];
				SEL_COIL_FB:    next_st.resp_data[0] = st.fb[st.pend_bit];
				SEL_COIL_STORE: next_st.resp_data[0] = st.store_sel;
				SEL_ERR:        next_st.resp_data    = st.err_code;
				SEL_INDEX:      next_st.resp_data    = st.arr_index;
				SEL_CMD_WORD:   next_st.resp_data    = st.cmd;
				SEL_SETPOINT:   next_st.resp_data    = st.setpoint;
				SEL_STATE_WORD: next_st.resp_data    = st.status;
				SEL_ACTUAL:     next_st.resp_data    = st.actual;
				SEL_PARAM:      next_st.resp_data    = mem_rdata;
				SEL_BAD:        next_st.resp_data    = `RST_WORD;
			endcase
		end
		// taking stage; refused writes leave every register untouched
		next_st.pend       = take;
		next_st.pend_sel   = sel;
		next_st.pend_bit   = coil_bit;
		next_st.pend_write = req_write;
		next_st.pend_exc   = (sel == SEL_BAD) || (req_write && read_only);
		if (take && req_write && !read_only) begin
			unique case (sel)
				SEL_COIL_CMD:   next_st.cmd[coil_bit]      = req_wdata[0];
				SEL_COIL_REF:   next_st.setpoint[coil_bit] = req_wdata[0];
				SEL_COIL_STORE: next_st.store_sel          = req_wdata[0];
				SEL_INDEX:      next_st.arr_index          = req_wdata;
				SEL_CMD_WORD:   next_st.cmd                = req_wdata;
				SEL_SETPOINT:   next_st.setpoint           = req_wdata;
				SEL_PARAM: begin
					// the index and storage choice travel with each write
					next_st.pw_strobe = 1'b1;
					next_st.pw_number = pnu;
					next_st.pw_value  = req_wdata;
					next_st.pw_index  = st.arr_index;
					next_st.pw_eeprom = st.store_sel;
				end
				default: next_st.pend_exc = next_st.pend_exc;
			endcase
		end
	end

	// single state register, frozen while the clock enable is low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st           <= '0;
			st.pend_sel  <= SEL_BAD;
			st.store_sel <= `RST_STORE_SEL;
		end else if (ce) begin
			st <= next_st;
		end
	end

	// parameter values; the store keeps one word per number, index is passed on
	param_store #(
		.WIDTH (16),
		.DEPTH (PARAM_COUNT),
		.AW    (PNU_W)
	) u_param_store (
		.clk     (clk),
		.ce      (ce),
		.wr_en   (take && req_write && sel == SEL_PARAM),
		.wr_addr (pnu),
		.wr_data (req_wdata),
		.rd_addr (pnu),
		.rd_data (mem_rdata)
	);

	// outputs straight from the state register
	assign resp_valid            = st.resp_valid;
	assign resp_data             = st.resp_data;
	assign resp_exception        = st.resp_exc;
	assign drive_command_word    = st.cmd;
	assign bus_speed_setpoint    = st.setpoint;
	assign preset_ref_sel        = st.cmd[`CMD_PRESET_LSB+1:`CMD_PRESET_LSB];
	assign setup_sel             = st.cmd[`CMD_SETUP_LSB+1:`CMD_SETUP_LSB];
	assign dc_brake_n            = st.cmd[`CMD_DC_BRAKE_N];
	assign coast_stop_n          = st.cmd[`CMD_COAST_N];
	assign quick_stop_n          = st.cmd[`CMD_QUICK_N];
	assign freeze_n              = st.cmd[`CMD_FREEZE_N];
	assign start                 = st.cmd[`CMD_START];
	assign fault_reset           = st.cmd[`CMD_RESET];
	assign jog                   = st.cmd[`CMD_JOG];
	assign ramp2_sel             = st.cmd[`CMD_RAMP2];
	assign data_valid            = st.cmd[`CMD_DATA_VALID];
	assign relay1_on             = st.cmd[`CMD_RELAY1];
	assign relay2_on             = st.cmd[`CMD_RELAY2];
	assign reverse               = st.cmd[`CMD_REVERSE];
	assign store_to_eeprom       = st.store_sel;
	assign last_error_code       = st.err_code;
	assign parameter_array_index = st.arr_index;
	assign param_wr_strobe       = st.pw_strobe;
	assign param_wr_number       = st.pw_number;
	assign param_wr_value        = st.pw_value;
	assign param_wr_index        = st.pw_index;
	assign param_wr_eeprom       = st.pw_eeprom;

	// checks hold while the clock enable stays high
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || !ce);

	AST_COIL_ZERO: assert property (req_valid && req_coil && req_write && req_addr == 16'h0000
		|=> drive_command_word[0] == $past(req_wdata[0]))
		else $error("coil address zero did not reach command bit zero");
	AST_HOLD_NO_PREFIX: assert property (req_valid && !req_coil && req_write
		&& req_addr == 16'hC34F |=> drive_command_word == $past(req_wdata))
		else $error("register 50000 write not taken at address C34F");
	AST_ONE_ANSWER: assert property (req_valid |-> ##2 resp_valid)
		else $error("item got no answer two cycles later");
	AST_SETPOINT_COIL: assert property (req_valid && req_coil && req_write
		&& req_addr == 16'h001F |=> bus_speed_setpoint[15] == $past(req_wdata[0]))
		else $error("coil 32 did not set setpoint msb");
	AST_STATE_RO: assert property (req_valid && !req_coil && req_write
		&& req_addr == 16'hC417 |-> ##2 resp_exception)
		else $error("state word write was not refused");
	AST_STORE_SEL: assert property (req_valid && req_coil && req_write && req_addr == 16'h0040
		|=> store_to_eeprom == $past(req_wdata[0]))
		else $error("coil 65 did not set storage select");
	AST_ERR_CODE: assert property (error_strobe |=> last_error_code == $past(error_code))
		else $error("error code not captured");
	AST_INDEX: assert property (req_valid && !req_coil && req_write && req_addr == 16'h0008
		|=> parameter_array_index == $past(req_wdata))
		else $error("array index not written at address 8");
	AST_PARAM_WR: assert property (req_valid && !req_coil && req_write && req_addr == 16'h0009
		|=> param_wr_strobe && param_wr_number == 1)
		else $error("register 10 write did not reach parameter 1");
	AST_RESERVED: assert property (req_valid && ((req_coil && req_addr > 16'h0040)
		|| (!req_coil && req_addr < 16'h0006)) |-> ##2 resp_valid && resp_exception)
		else $error("reserved address not refused");

	COV_STATUS_READ: cover property (req_valid && req_coil && !req_write
		&& req_addr == 16'h0020 ##2 resp_valid);
	COV_PARAM_WRITE: cover property (param_wr_strobe && param_wr_eeprom);
	COV_EXCEPTION: cover property (resp_valid && resp_exception);
endmodule : modbus_coil_register_map

// >>> hw/modbus_map_consts.svh
// coil and holding-register numbers, field positions and reset values of the map
`ifndef MODBUS_MAP_CONSTS_SVH
`define MODBUS_MAP_CONSTS_SVH

// coil groups, as zero-based addresses carried in a message
`define COIL_CMD_BASE      16'h0000
`define COIL_REF_BASE      16'h0010
`define COIL_STAT_BASE     16'h0020
`define COIL_FB_BASE       16'h0030
`define COIL_STORE_SEL     16'h0040

// holding registers, as register numbers seen by users (address = number - 1)
`define REG_ERR_CODE       17'h00007
`define REG_ARRAY_INDEX    17'h00009
`define REG_PARAM_FIRST    17'h0000A
`define REG_PARAM_LAST     17'h0C346
`define REG_PARAM_STRIDE   17'h0000A
`define REG_CMD_WORD       17'h0C350
`define REG_SETPOINT       17'h0C35A
`define REG_STATE_WORD     17'h0C418
`define REG_ACTUAL         17'h0C422
`define REG_NUM_ONE        17'h00001

// command word bit positions
`define CMD_PRESET_LSB     0
`define CMD_DC_BRAKE_N     2
`define CMD_COAST_N        3
`define CMD_QUICK_N        4
`define CMD_FREEZE_N       5
`define CMD_START          6
`define CMD_RESET          7
`define CMD_JOG            8
`define CMD_RAMP2          9
`define CMD_DATA_VALID     10
`define CMD_RELAY1         11
`define CMD_RELAY2         12
`define CMD_SETUP_LSB      13
`define CMD_REVERSE        15

// state word bit positions
`define STW_CTRL_READY     0
`define STW_CONV_READY     1
`define STW_SAFETY_CLOSED  2
`define STW_ALARM          3
`define STW_WARNING        7
`define STW_AT_REF         8
`define STW_AUTO           9
`define STW_IN_RANGE       10
`define STW_RUNNING        11
`define STW_VOLT_WARN      13
`define STW_CURR_LIMIT     14
`define STW_THERMAL_WARN   15

// reset values and the default parameter count
`define RST_WORD           16'h0000
`define RST_STORE_SEL      1'b0
`define DEFAULT_PARAMS     5000

`endif

// >>> hw/modbus_map_pkg.sv
// types shared by the coil and register map, its bench and the master model
package modbus_map_pkg;
	// target of one decoded access
	typedef enum logic [3:0] {
		SEL_BAD,
		SEL_COIL_CMD,
		SEL_COIL_REF,
		SEL_COIL_STAT,
		SEL_COIL_FB,
		SEL_COIL_STORE,
		SEL_ERR,
		SEL_INDEX,
		SEL_CMD_WORD,
		SEL_SETPOINT,
		SEL_STATE_WORD,
		SEL_ACTUAL,
		SEL_PARAM
	} sel_t;

	typedef logic [15:0] word_t;
endpackage : modbus_map_pkg

// >>> hw/param_store.sv
// parameter value memory with registered read data
`timescale 1ns/100ps
module param_store #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 5000,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clk,
	input  wire logic             ce,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	// read port register, the only control-free state
	typedef struct packed {
		logic [WIDTH-1:0] rd_data;
	} st_t;

	logic [WIDTH-1:0] mem [DEPTH];  // value storage, no reset (ram)
	st_t              st;           // registered state
	st_t              next_st;      // next state

	// read data follows the addressed word
	always_comb begin
		next_st         = st;
		next_st.rd_data = mem[rd_addr];
	end

	// read first, read sees the old word in the same edge
	always_ff @(posedge clk) begin
		if (ce) begin
			st <= next_st;
			if (wr_en) begin
				mem[wr_addr] <= wr_data;
			end
		end
	end

	assign rd_data = st.rd_data;
endmodule : param_store

// >>> tb/modbus_coil_register_map_tb.sv
// self-checking bench for the coil and holding-register map
`timescale 1ns/100ps
`include "modbus_map_consts.svh"
module modbus_coil_register_map_tb;
	import modbus_map_pkg::*;
	logic        clk;
	logic        reset;
	logic [11:0] stat;	// status levels in port order
	logic        closed_loop;
	word_t       freq, fbk, act, err_code;
	logic        err_strobe;
	logic        req_valid, req_coil, req_write, resp_valid, resp_exception;
	logic [15:0] req_addr;
	word_t       req_wdata, resp_data, cmd_word, setpoint, last_err, arr_idx, wr_val, wr_idx;
	logic [15:0] dec;	// decoded command outputs laid out as the command word
	logic        store_ee, wr_strobe, wr_ee;
	logic [3:0]  wr_num;
	logic [16:0] r;	// last answer: exception, data
	logic [51:0] rows[20];	// user coil or register item beside its expected answer
	int          pos[12] = '{0, 1, 2, 3, 7, 8, 9, 10, 11, 13, 14, 15};
	int          err_count, num_checks, cycles, n_strobe, i, m;

	// small parameter memory keeps the run short; parameter 16 and up is then refused
	modbus_coil_register_map #(.PARAM_COUNT(16)) dut (
		.clk(clk), .reset(reset), .ce(1'b1), .req_valid(req_valid), .req_coil(req_coil),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.resp_valid(resp_valid), .resp_data(resp_data), .resp_exception(resp_exception),
		.control_ready(stat[0]), .converter_ready(stat[1]), .safety_closed(stat[2]),
		.alarm(stat[3]), .warning(stat[4]), .at_reference(stat[5]), .auto_mode(stat[6]),
		.in_freq_range(stat[7]), .running(stat[8]), .voltage_warning(stat[9]),
		.current_limit(stat[10]), .thermal_warning(stat[11]), .closed_loop(closed_loop),
		.output_frequency(freq), .feedback_value(fbk), .actual_value(act),
		.error_strobe(err_strobe), .error_code(err_code), .drive_command_word(cmd_word),
		.bus_speed_setpoint(setpoint), .preset_ref_sel(dec[1:0]), .setup_sel(dec[14:13]),
		.dc_brake_n(dec[2]), .coast_stop_n(dec[3]), .quick_stop_n(dec[4]), .freeze_n(dec[5]),
		.start(dec[6]), .fault_reset(dec[7]), .jog(dec[8]), .ramp2_sel(dec[9]),
		.data_valid(dec[10]), .relay1_on(dec[11]), .relay2_on(dec[12]), .reverse(dec[15]),
		.store_to_eeprom(store_ee), .last_error_code(last_err), .parameter_array_index(arr_idx),
		.param_wr_strobe(wr_strobe), .param_wr_number(wr_num), .param_wr_value(wr_val),
		.param_wr_index(wr_idx), .param_wr_eeprom(wr_ee)
	);
	modbus_master_model mst (
		.clk(clk), .req_valid(req_valid), .req_coil(req_coil), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
		.resp_data(resp_data), .resp_exception(resp_exception)
	);

	// free-running clock, 8 ns period
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// counts parameter notices and cuts a hang short
	always @(negedge clk) begin
		cycles++;
		if (wr_strobe === 1'b1) begin
			n_strobe++;
		end
		if (cycles == 6000) begin
			err_count++;
			give_verdict();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	// one item through the master model; a missing answer leaves r unknown and fails
	task automatic xfer(input logic c, input logic w, input logic [16:0] n, input word_t d);
		@(posedge clk);
		mst.send(c, w, n, d);
		for (int k = 0; k < 20 && mst.ans.size() == 0; k++) @(negedge clk);
		r = (mst.ans.size() > 0) ? mst.ans.pop_front() : 'x;
	endtask : xfer

	initial begin
		reset = 1'b1;
		stat = 12'h000;
		closed_loop = 1'b0;
		freq = 16'h8001;
		fbk = 16'h4000;
		act = 16'h1357;
		err_code = 16'h0000;
		err_strobe = 1'b0;
		// c, w, user number, data, exception, read data
		rows = '{
			{1'b0, 1'b1, `REG_SETPOINT, 16'hA5C3, 1'b0, 16'h0000},
			{1'b1, 1'b0, 17'h00011, 16'h0000, 1'b0, 16'h0001},
			{1'b1, 1'b0, 17'h00012, 16'h0000, 1'b0, 16'h0001},
			{1'b1, 1'b0, 17'h00013, 16'h0000, 1'b0, 16'h0000},
			{1'b1, 1'b0, 17'h00020, 16'h0000, 1'b0, 16'h0001},
			{1'b0, 1'b0, `REG_SETPOINT, 16'h0000, 1'b0, 16'hA5C3},
			{1'b0, 1'b1, `REG_ARRAY_INDEX, 16'h0003, 1'b0, 16'h0000},
			{1'b0, 1'b0, `REG_ARRAY_INDEX, 16'h0000, 1'b0, 16'h0003},
			{1'b1, 1'b1, 17'h00041, 16'h0001, 1'b0, 16'h0000},
			{1'b0, 1'b1, 17'h0001E, 16'hBEEF, 1'b0, 16'h0000},
			{1'b0, 1'b0, 17'h0001E, 16'h0000, 1'b0, 16'hBEEF},
			{1'b0, 1'b1, 17'h00023, 16'h1111, 1'b1, 16'h0000},
			{1'b0, 1'b0, 17'h000A0, 16'h0000, 1'b1, 16'h0000},
			{1'b0, 1'b0, 17'h00001, 16'h0000, 1'b1, 16'h0000},
			{1'b0, 1'b1, 17'h00008, 16'h2222, 1'b1, 16'h0000},
			{1'b1, 1'b0, 17'h00042, 16'h0000, 1'b1, 16'h0000},
			{1'b0, 1'b1, `REG_STATE_WORD, 16'h3333, 1'b1, 16'h0000},
			{1'b0, 1'b1, `REG_ERR_CODE, 16'h4444, 1'b1, 16'h0000},
			{1'b0, 1'b0, `REG_ACTUAL, 16'h0000, 1'b0, 16'h1357},
			{1'b1, 1'b1, 17'h00032, 16'h0001, 1'b1, 16'h0000}
		};
		repeat (5) @(negedge clk);
		check({cmd_word, setpoint, arr_idx}, 48'h0);
		check({store_ee, resp_valid, resp_exception, wr_strobe}, 4'h0);
		reset = 1'b0;
		// ordinary items from the table; exceptions must leave no trace
		for (i = 0; i < 20; i++) begin
			xfer(rows[i][51], rows[i][50], rows[i][49:33], rows[i][32:17]);
			check(r, rows[i][16:0]);
		end
		check({setpoint, arr_idx, store_ee}, {16'hA5C3, 16'h0003, 1'b1});
		check({wr_num, wr_val, wr_idx, wr_ee}, {4'h3, 16'hBEEF, 16'h0003, 1'b1});
		check(n_strobe, 1);
		// register 10 is parameter 1; coil 32 alone clears the setpoint msb
		xfer(1'b0, 1'b1, 17'h0000A, 16'h1234);
		check({r, wr_num, wr_val}, {17'h00000, 4'h1, 16'h1234});
		xfer(1'b1, 1'b1, 17'h00020, 16'h0000);
		check({r, setpoint}, {17'h00000, 16'h25C3});
		$display("table test done");
		// each status level alone, by word and by its own coil
		for (i = 0; i < 12; i++) begin
			@(negedge clk);
			stat = 12'h001 << i;
			xfer(1'b0, 1'b0, `REG_STATE_WORD, 16'h0000);
			check(r, 17'h00001 << pos[i]);
			xfer(1'b1, 1'b0, 17'(33 + pos[i]), 16'h0000);
			check(r, 17'h00001);
		end
		stat = 12'hFFF;
		xfer(1'b0, 1'b0, `REG_STATE_WORD, 16'h0000);
		check(r, 17'h0EF8F);
		xfer(1'b1, 1'b0, 17'h00025, 16'h0000);
		check(r, 17'h00000);
		$display("status test done");
		// frequency in open loop, feedback in closed loop
		for (m = 0; m < 2; m++) begin
			closed_loop = m[0];
			xfer(1'b1, 1'b0, 17'h00031, 16'h0000);
			check(r, {16'h0000, ~m[0]});
			xfer(1'b1, 1'b0, 17'(64 - m), 16'h0000);
			check(r, 17'h00001);
		end
		$display("feedback test done");
		// every command bit by register, then read back by coil
		for (i = 0; i < 16; i++) begin
			xfer(1'b0, 1'b1, `REG_CMD_WORD, 16'h0001 << i);
			check({dec, cmd_word}, {2{16'h0001 << i}});
			xfer(1'b1, 1'b0, 17'(i + 1), 16'h0000);
			check(r, 17'h00001);
		end
		// back-to-back coil writes build the preset selector
		xfer(1'b0, 1'b1, `REG_CMD_WORD, 16'h0000);
		@(posedge clk);
		mst.send(1'b1, 1'b1, 17'h00001, 16'h0001);
		mst.send(1'b1, 1'b1, 17'h00002, 16'h0001);
		for (int k = 0; k < 20 && mst.ans.size() < 2; k++) @(negedge clk);
		check(mst.ans.size(), 2);
		// both answers were counted here, so drop them before the next single item
		mst.ans.delete();
		check({cmd_word, dec[1:0]}, {16'h0003, 2'b11});
		$display("command test done");
		// error capture, then a later code without strobe is ignored
		@(negedge clk);
		err_code = 16'h00E5;
		err_strobe = 1'b1;
		@(negedge clk);
		err_strobe = 1'b0;
		err_code = 16'hFFFF;
		xfer(1'b0, 1'b0, `REG_ERR_CODE, 16'h0000);
		check({r, last_err}, {17'h000E5, 16'h00E5});
		$display("error test done");
		// reset in mid-run clears the map
		@(negedge clk);
		reset = 1'b1;
		@(negedge clk);
		check({cmd_word, setpoint, last_err, store_ee}, 49'h0);
		reset = 1'b0;
		xfer(1'b0, 1'b0, `REG_CMD_WORD, 16'h0000);
		check(r, 17'h00000);
		$display("reset test done");
		give_verdict();
	end
endmodule : modbus_coil_register_map_tb

// >>> tb/modbus_master_model.sv
// frame-layer master model: puts queued items on the item port and gathers the answers
`timescale 1ns/100ps
module modbus_master_model (
	input  wire logic                  clk,
	output logic                       req_valid,
	output logic                       req_coil,
	output logic                       req_write,
	output logic [15:0]                req_addr,
	output modbus_map_pkg::word_t      req_wdata,
	input  wire logic                  resp_valid,
	input  wire modbus_map_pkg::word_t resp_data,
	input  wire logic                  resp_exception
);
	import modbus_map_pkg::*;
	logic [34:0] pend[$];	// queued items: coil, write, user number, data
	logic [16:0] ans[$];	// answers in arrival order: exception, data
	logic [34:0] cur;	// item now on the wires
	initial begin
		req_valid = 1'b0;
		req_coil  = 1'b0;
		req_write = 1'b0;
		req_addr  = 16'h0000;
		req_wdata = 16'h0000;
	end
	// queue one item given in user numbering
	task automatic send(input logic c, input logic w, input logic [16:0] n, input word_t d);
		pend.push_back({c, w, n, d});
	endtask : send
	// one item per cycle; released address and data wires show the inverse so a stale value is never read as good
	always @(negedge clk) begin
		if (pend.size() > 0) begin
			cur = pend.pop_front();
			req_valid <= 1'b1;
			req_coil  <= cur[34];
			req_write <= cur[33];
			req_addr  <= 16'(cur[32:16] - 17'h00001);
			req_wdata <= cur[15:0];
		end else begin
			req_valid <= 1'b0;
			req_addr  <= ~req_addr;
			req_wdata <= ~req_wdata;
		end
		// answers stand one cycle, so each is looked at in mid-cycle
		if (resp_valid === 1'b1) begin
			ans.push_back({resp_exception, resp_data});
		end
	end
endmodule : modbus_master_model
